//--- verilog/wcbc_top.sv
// write crc checker for four-beat burst chop frames, avalon-mm register slave
//
// Contract
// - With write crc and four-beat burst chop on, A2 chooses which half of each lane slot holds the data.
// - An x4 device feeds 16 real bits to the tree and every other input is one.
// - With A2 set, each lane's beats land on the upper four inputs of that lane's slot.
// - An x8 device feeds 36 real bits: four beats of eight data lanes and of the mask lane.
// - On x8 with A2 clear, inputs 67:64 take the mask lane when mask or inversion is on, else one.
// - On x8 with A2 set, inputs 71:68 take the mask lane when mask or inversion is on, else one.
// - The x8 frame has ones in beats 4 to 7 and 9, crc bit n on lane n in beat 8, one on the mask lane.
// - The x4 frame has ones in beats 4 to 7, crc bit n in beat 8 and bit n+4 in beat 9 on lane n.
// - An x16 device has two identical trees, one per byte, 36 real inputs each.
// - The lower mask lane feeds 67:64 with A2 clear and 71:68 with A2 set, if enabled, else ones.
// - With A2 clear the upper mask lane feeds 139:136 if enabled, else ones.
// - With A2 set the upper mask lane feeds 143:140 if enabled, else ones.
// - The x16 frame carries crc bits 8 to 15 on lanes 8 to 15 in beat 8, ones elsewhere after beat 3.
// - Each tree forms an 8-bit crc with x^8+x^2+x+1 over 72 inputs from a zero start.
// - The tree input stream starts with input 71.
// - A mismatch sets bit 3 of mode register five, which stays set until a mode register write clears it.
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`include "wcbc_defines.svh"
module wcbc_top (
   input wire logic MCLK_I,
   input wire logic SYS_RST_I,
   input wire logic [4:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   input wire logic WR_VALID_I,
   input wire logic WR_FIRST_I,
   input wire logic WR_A2_I,
   input wcbc_pkg::wcbc_beat_t WR_BEAT_I,
   output logic CRC_ERR_O,
   output logic IRQ_O
);
   import wcbc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // state
   // gray-coded states keep the idle-receive-check path one bit per step
   wcbc_ctrl_t ctrl_ff;
   wcbc_state_t state_ff;
   wcbc_state_t nxt_state;
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   wcbc_beat_t [9:0] beats_ff;
   logic a2_ff;
   logic err_ff;
   logic nxt_err;
   logic [`WCBC_IRQ_W-1:0] irq_stat_ff;
   logic [`WCBC_IRQ_W-1:0] irq_en_ff;
   logic [`WCBC_IRQ_W-1:0] nxt_irq_stat;
   logic irq_ff;
   logic [15:0] crc_calc_ff;
   logic [15:0] crc_rx_ff;
   logic [15:0] frames_ff;
   logic wait_ff;
   logic [31:0] rdata_ff;

   ////////////////////////////////////////////////////////////////////////////
   // frame capture
   // a beat is stored on a frame start in idle or while receiving; the check cycle ignores the bus
   wire logic start_frame = WR_VALID_I && WR_FIRST_I && ctrl_ff.crc_en;
   wire logic take_beat = (state_ff == WCBC_IDLE) ? start_frame : (state_ff == WCBC_RECV) && WR_VALID_I;
   wire logic [3:0] beat_idx = (state_ff == WCBC_IDLE || WR_FIRST_I) ? 4'h0 : cnt_ff;
   wire logic last_beat = take_beat && (beat_idx == `WCBC_LAST_BEAT);

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      case (state_ff)
         WCBC_IDLE: begin
            if (start_frame) begin
               nxt_state = WCBC_RECV;
               nxt_cnt = 4'h1;
            end
         end
         WCBC_RECV: begin
            // a fresh first beat restarts the frame, a partial one is dropped
            if (take_beat) begin
               nxt_cnt = beat_idx + 4'h1;
            end
            if (last_beat) begin
               nxt_state = WCBC_CHECK;
            end
         end
         WCBC_CHECK: begin
            nxt_state = WCBC_IDLE;
            nxt_cnt = 4'h0;
         end
         default: begin
            nxt_state = WCBC_IDLE;
            nxt_cnt = 4'h0;
         end
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         state_ff <= WCBC_IDLE;
         cnt_ff <= 4'h0;
         a2_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         if (take_beat && beat_idx == 4'h0)
            a2_ff <= WR_A2_I;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I)
         beats_ff <= '1;
      else if (take_beat)
         beats_ff[beat_idx] <= WR_BEAT_I;
   end

   ////////////////////////////////////////////////////////////////////////////
   // tree inputs and crc trees
   logic [71:0] tree_lo;
   logic [71:0] tree_hi;
   logic [7:0] crc_lo;
   logic [7:0] crc_hi;

   // lower byte mapping, mask lane at 67:64 or 71:68
   wcbc_map #(.UPPER(1'b0)) u_map_lo (
      .beats_i(beats_ff),
      .a2_i(a2_ff),
      .bc4_i(ctrl_ff.bc4_en),
      .width_i(ctrl_ff.width),
      .mask_en_i(ctrl_ff.mask_en),
      .tree_o(tree_lo)
   );

   // upper byte mapping, mask lane at 139:136 or 143:140
   wcbc_map #(.UPPER(1'b1)) u_map_hi (
      .beats_i(beats_ff),
      .a2_i(a2_ff),
      .bc4_i(ctrl_ff.bc4_en),
      .width_i(ctrl_ff.width),
      .mask_en_i(ctrl_ff.mask_en),
      .tree_o(tree_hi)
   );

   wcbc_crc8 u_crc_lo (
      .tree_i(tree_lo),
      .crc_o(crc_lo)
   );

   // limitation: the upper tree also runs for x4 and x8; there its result is recorded but never compared
   // second identical tree
   wcbc_crc8 u_crc_hi (
      .tree_i(tree_hi),
      .crc_o(crc_hi)
   );

   ////////////////////////////////////////////////////////////////////////////
   // received crc and frame shape
   // width picks lanes
   wire logic is_x4 = (ctrl_ff.width == WCBC_X4);
   wire logic is_x16 = (ctrl_ff.width == WCBC_X16);

   // x4 crc split over beats 8 and 9
   wire logic [7:0] rx_lo = is_x4 ?
      {beats_ff[`WCBC_CRC_HI_BEAT].dq[3:0], beats_ff[`WCBC_CRC_BEAT].dq[3:0]} : beats_ff[`WCBC_CRC_BEAT].dq[7:0];
   // upper crc on lanes 8 to 15
   wire logic [7:0] rx_hi = beats_ff[`WCBC_CRC_BEAT].dq[15:8];

   // filler beats must be ones on every lane that the width uses
   function automatic logic filler_bad(input wcbc_beat_t [9:0] b, input wcbc_width_t w, input logic bc4);
      logic [17:0] used;
      logic bad;
      used = (w == WCBC_X4) ? 18'h0000f : (w == WCBC_X8) ? 18'h100ff : 18'h3ffff;
      bad = 1'b0;
      for (int k = `WCBC_CHOP_BEATS; k < 8; k++)
         bad = bad | (bc4 && ((~b[k] & used) != 18'h0));
      if (w != WCBC_X4) begin
         bad = bad | ((~b[`WCBC_CRC_HI_BEAT] & used) != 18'h0);
         bad = bad | ((~b[`WCBC_CRC_BEAT].mask & used[17:16]) != 2'h0);
      end
      return bad;
   endfunction

   // ones after data and beside crc
   wire logic shape_bad = filler_bad(beats_ff, ctrl_ff.width, ctrl_ff.bc4_en);
   wire logic mismatch = (crc_lo != rx_lo) || (is_x16 && (crc_hi != rx_hi));
   wire logic checking = (state_ff == WCBC_CHECK);
   wire logic [15:0] crc_local = {crc_hi, crc_lo};
   wire logic [15:0] crc_recv = {rx_hi, rx_lo};

   ////////////////////////////////////////////////////////////////////////////
   // register bus
   wire logic req = AVS_READ_I || AVS_WRITE_I;
   wire logic wr_go = AVS_WRITE_I && !wait_ff;
   wire logic lo_be = AVS_BYTEENABLE_I[0];
   wire logic wr_ctrl = wr_go && lo_be && (AVS_ADDRESS_I == `WCBC_OFF_CTRL);
   wire logic wr_mode5 = wr_go && lo_be && (AVS_ADDRESS_I == `WCBC_OFF_MODE5);
   wire logic wr_clr = wr_go && lo_be && (AVS_ADDRESS_I == `WCBC_OFF_IRQ_CLR);
   wire logic wr_en = wr_go && lo_be && (AVS_ADDRESS_I == `WCBC_OFF_IRQ_EN);

   function automatic logic [31:0] rd_sel(input logic [4:0] a, input wcbc_ctrl_t c, input logic e,
                                          input logic [2:0] st, input logic [2:0] en,
                                          input logic [15:0] cc, input logic [15:0] cr,
                                          input logic [15:0] fr);
      logic [31:0] r;
      r = 32'h0;
      case (a)
         `WCBC_OFF_CTRL: r = {27'h0, c};
         `WCBC_OFF_MODE5: r = {28'h0, e, 3'h0};
         `WCBC_OFF_IRQ_STAT: r = {29'h0, st};
         `WCBC_OFF_IRQ_EN: r = {29'h0, en};
         `WCBC_OFF_CRC: r = {cr, cc};
         `WCBC_OFF_FRAMES: r = {16'h0, fr};
         default: r = 32'h0;
      endcase
      return r;
   endfunction

   wire logic [31:0] rd_mux = rd_sel(AVS_ADDRESS_I, ctrl_ff, err_ff, irq_stat_ff, irq_en_ff,
                                     crc_calc_ff, crc_rx_ff, frames_ff);

   // one wait cycle: waitrequest drops on the cycle after the request appears
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         wait_ff <= 1'b1;
         rdata_ff <= 32'h0;
      end else begin
         wait_ff <= !(req && wait_ff);
         if (AVS_READ_I && wait_ff)
            rdata_ff <= rd_mux;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         ctrl_ff <= `WCBC_CTRL_RST;
         irq_en_ff <= `WCBC_IRQ_EN_RST;
      end else begin
         if (wr_ctrl)
            ctrl_ff <= AVS_WRITEDATA_I[4:0];
         if (wr_en)
            irq_en_ff <= AVS_WRITEDATA_I[`WCBC_IRQ_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // error flag, results and interrupts
   wire logic ev_mis = checking && mismatch;
   wire logic ev_done = checking;
   // shape only flags; the error bit stays a pure crc verdict
   wire logic ev_shape = checking && ctrl_ff.bc4_en && shape_bad;
   wire logic [`WCBC_IRQ_W-1:0] events = {ev_shape, ev_done, ev_mis};
   // a mode five write with the error bit clear is the only way out
   wire logic err_clr = wr_mode5 && !AVS_WRITEDATA_I[`WCBC_MODE5_ERR_BIT];
   wire logic [`WCBC_IRQ_W-1:0] clr_bits = wr_clr ? AVS_WRITEDATA_I[`WCBC_IRQ_W-1:0] : '0;

   assign nxt_err = ev_mis || (err_ff && !err_clr);
   // a new event wins over a clear in the same cycle
   assign nxt_irq_stat = (irq_stat_ff & ~clr_bits) | events;

   // the irq flop looks at next status so it rises together with the status bit

   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         err_ff <= 1'b0;
         irq_stat_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         err_ff <= nxt_err;
         irq_stat_ff <= nxt_irq_stat;
         irq_ff <= |(nxt_irq_stat & irq_en_ff);
      end
   end

   // results kept for software; frame count wraps
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         crc_calc_ff <= 16'h0;
         crc_rx_ff <= 16'h0;
         frames_ff <= 16'h0;
      end else if (checking) begin
         crc_calc_ff <= crc_local;
         crc_rx_ff <= crc_recv;
         frames_ff <= frames_ff + 16'h1;
      end
   end

   assign AVS_WAITREQUEST_O = wait_ff;
   assign AVS_READDATA_O = rdata_ff;
   assign CRC_ERR_O = err_ff;
   assign IRQ_O = irq_ff;
endmodule // wcbc_top

//--- verilog/wcbc_defines.svh
// offsets, field positions, reset values and frame counts of the write crc checker
`ifndef WCBC_DEFINES_SVH
`define WCBC_DEFINES_SVH
`define WCBC_OFF_CTRL 5'h00
`define WCBC_OFF_MODE5 5'h04
`define WCBC_OFF_IRQ_STAT 5'h08
`define WCBC_OFF_IRQ_CLR 5'h0c
`define WCBC_OFF_IRQ_EN 5'h10
`define WCBC_OFF_CRC 5'h14
`define WCBC_OFF_FRAMES 5'h18
`define WCBC_MODE5_ERR_BIT 3
`define WCBC_IRQ_MISMATCH 0
`define WCBC_IRQ_DONE 1
`define WCBC_IRQ_FORMAT 2
`define WCBC_IRQ_W 3
`define WCBC_CTRL_RST 5'h00
`define WCBC_IRQ_EN_RST 3'h0
`define WCBC_LAST_BEAT 4'h9
`define WCBC_CRC_BEAT 8
`define WCBC_CRC_HI_BEAT 9
`define WCBC_CHOP_BEATS 4
`define WCBC_LANES 9
`define WCBC_TREE_W 72
`endif

//--- verilog/wcbc_pkg.sv
// types shared by the write crc checker
package wcbc_pkg;
   typedef enum logic [1:0] {
      WCBC_X4 = 2'h0,
      WCBC_X8 = 2'h1,
      WCBC_X16 = 2'h2
   } wcbc_width_t;
   // gray along idle -> receive -> check
   typedef enum logic [1:0] {
      WCBC_IDLE = 2'h0,
      WCBC_RECV = 2'h1,
      WCBC_CHECK = 2'h3
   } wcbc_state_t;
   // one transfer on the data bus: lanes 15:0 and both mask/inversion lanes
   typedef struct packed {
      logic [1:0] mask;
      logic [15:0] dq;
   } wcbc_beat_t;
   typedef struct packed {
      logic mask_en;
      wcbc_width_t width;
      logic bc4_en;
      logic crc_en;
   } wcbc_ctrl_t;
endpackage

//--- verilog/wcbc_crc8.sv
// one 8-bit crc tree over 72 inputs
`timescale 1ns/10ps
module wcbc_crc8 (
   input wire logic [71:0] tree_i,
   output logic [7:0] crc_o
);
   // serial form of x^8+x^2+x+1; the tree collapses it to xor gates
   function automatic logic [7:0] crc_calc(input logic [71:0] d);
      logic [7:0] c;
      logic fb;
      c = 8'h00;
      fb = 1'b0;
      for (int i = 71; i >= 0; i--) begin
         fb = c[7] ^ d[i];
         c = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
      end
      return c;
   endfunction

   assign crc_o = crc_calc(tree_i);
endmodule // wcbc_crc8

//--- verilog/wcbc_map.sv
// maps one byte's captured frame onto the 72 tree inputs
`timescale 1ns/10ps
`include "wcbc_defines.svh"
module wcbc_map #(
   parameter bit UPPER = 1'b0
) (
   input wcbc_pkg::wcbc_beat_t [9:0] beats_i,
   input wire logic a2_i,
   input wire logic bc4_i,
   input wcbc_pkg::wcbc_width_t width_i,
   input wire logic mask_en_i,
   output logic [71:0] tree_o
);
   import wcbc_pkg::*;

   function automatic logic [71:0] map_tree(input wcbc_beat_t [9:0] b, input logic a2,
                                             input logic bc4, input wcbc_width_t w,
                                             input logic men);
      logic [71:0] d;
      logic live;
      logic v;
      int base;
      d = '1;
      live = 1'b0;
      v = 1'b0;
      base = 0;
      for (int ln = 0; ln < `WCBC_LANES; ln++) begin
         // x4 uses four lanes only; the mask lane counts only when mask or inversion is on
         // lane count per width
         if (ln == 8)
            live = men && (w != WCBC_X4);
         else
            live = (w != WCBC_X4) || (ln < 4);
         for (int k = 0; k < 8; k++) begin
            // lane index folded so the unused branch never points past the bus
            v = (ln == 8) ? b[k].mask[UPPER] : b[k].dq[(UPPER ? 8 : 0) + (ln % 8)];
            base = (bc4 && a2) ? ln * 8 + 4 : ln * 8;
            if (live && (!bc4 || k < `WCBC_CHOP_BEATS))
               d[base + k] = v;
         end
      end
      return d;
   endfunction

   assign tree_o = map_tree(beats_i, a2_i, bc4_i, width_i, mask_en_i);
endmodule // wcbc_map

//--- test/wcbc_chk.sv
// port-level checks of the write crc checker
`timescale 1ns/10ps
module wcbc_chk (
   input wire logic MCLK_I,
   input wire logic SYS_RST_I,
   input wire logic [4:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   input wire logic [31:0] AVS_READDATA_O,
   input wire logic AVS_WAITREQUEST_O,
   input wire logic WR_VALID_I,
   input wire logic WR_FIRST_I,
   input wire logic WR_A2_I,
   input wcbc_pkg::wcbc_beat_t WR_BEAT_I,
   input wire logic CRC_ERR_O,
   input wire logic IRQ_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (SYS_RST_I);
   ////////////////////////////////////////
   chk_wait_single: assert property ($fell(AVS_WAITREQUEST_O) |=> AVS_WAITREQUEST_O)
      else $error("wait low too long");
   chk_wait_answer: assert property ($rose(AVS_READ_I || AVS_WRITE_I) |-> ##[1:2] !AVS_WAITREQUEST_O)
      else $error("no bus answer");
   chk_wait_idle: assert property (!(AVS_READ_I || AVS_WRITE_I) |-> AVS_WAITREQUEST_O)
      else $error("wait low without request");
   chk_reset_quiet: assert property ($fell(SYS_RST_I) |-> AVS_WAITREQUEST_O && !CRC_ERR_O && !IRQ_O)
      else $error("outputs not quiet after reset");
   chk_unmapped_zero: assert property (AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I > 5'h18
      |-> AVS_READDATA_O == 32'h0) else $error("unmapped read not zero");
   chk_err_cause: assert property ($rose(CRC_ERR_O) |-> $past(WR_VALID_I, 2))
      else $error("error set without frame end");
   chk_err_clear: assert property ($fell(CRC_ERR_O) |-> $past(AVS_WRITE_I && !AVS_WAITREQUEST_O
      && AVS_BYTEENABLE_I[0] && AVS_ADDRESS_I == 5'h04 && !AVS_WRITEDATA_I[3])) else $error("bad error clear");
   chk_err_hold: assert property (CRC_ERR_O && !(AVS_WRITE_I && AVS_ADDRESS_I == 5'h04) |=> CRC_ERR_O)
      else $error("error not sticky");
   chk_irq_cause: assert property ($rose(IRQ_O) |-> $past(WR_VALID_I, 2) || $past(AVS_WRITE_I, 2))
      else $error("irq without cause");
   cover property ($rose(CRC_ERR_O));
   cover property ($rose(IRQ_O));
   cover property ($fell(CRC_ERR_O));
endmodule // wcbc_chk

//--- test/wcbc_ctl_model.sv
// controller model: drives four-beat chopped write frames with crc
`timescale 1ns/10ps
module wcbc_ctl_model (
   input wire logic clk_i,
   output logic valid_o,
   output logic first_o,
   output logic a2_o,
   output wcbc_pkg::wcbc_beat_t beat_o
);
   import wcbc_pkg::*;
   wcbc_beat_t fr [10];
   initial begin
      valid_o = 1'b0;
      first_o = 1'b0;
      a2_o = 1'b0;
      beat_o = '0;
   end
   ////////////////////////////////////////
   // serial tree from zero
   function automatic logic [7:0] crc8(input logic [71:0] t);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 71; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ t[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction
   function automatic logic [71:0] tree(input int up, input logic a2, input wcbc_width_t w, input logic men);
      logic [71:0] t;
      t = '1;
      for (int n = 0; n < ((w == WCBC_X4) ? 4 : 8); n++)
         for (int k = 0; k < 4; k++) t[n * 8 + k + 4 * a2] = fr[k].dq[n + 8 * up];
      if (men && w != WCBC_X4)
         for (int k = 0; k < 4; k++) t[64 + k + 4 * a2] = fr[k].mask[up];
      return t;
   endfunction
   ////////////////////////////////////////
   task automatic send(input logic a2, input wcbc_width_t w, input logic men, input logic bad, input logic shp,
                       input logic slow, output logic [15:0] crc);
      logic [7:0] lo;
      logic [7:0] hi;
      for (int k = 0; k < 10; k++) begin
         fr[k] = '1;
         if (k < 4) fr[k] = wcbc_beat_t'(18'($urandom));
      end
      lo = crc8(tree(0, a2, w, men));
      hi = crc8(tree(1, a2, w, men));
      // crc in beat 8; x4 splits it over beats 8 and 9
      if (w == WCBC_X4) begin
         fr[8].dq[3:0] = lo[3:0];
         fr[9].dq[3:0] = lo[7:4];
      end else fr[8].dq[7:0] = lo;
      if (w == WCBC_X16) fr[8].dq[15:8] = hi;
      fr[8].dq[0] ^= bad;
      fr[5].dq[0] = !shp;
      crc = {hi, lo};
      for (int k = 0; k < 10; k++) begin
         @(posedge clk_i);
         // a slow controller leaves a gap; the bus shows garbage there
         if (slow && k == 5) begin
            valid_o <= 1'b0;
            beat_o <= ~beat_o;
            @(posedge clk_i);
         end
         valid_o <= 1'b1;
         first_o <= (k == 0);
         a2_o <= a2;
         beat_o <= fr[k];
      end
      @(posedge clk_i);
      valid_o <= 1'b0;
      first_o <= 1'b0;
      a2_o <= ~a2;
      beat_o <= ~fr[9];
   endtask
endmodule // wcbc_ctl_model

//--- test/wcbc_tb_top.sv
// self-checking bench of the write crc checker
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module wcbc_tb_top;
   import wcbc_pkg::*;
   logic clk, rst, rd, wr, wreq, vld, fst, a2p, err, irq, a2, men, bad, shp;
   logic [4:0] addr;
   logic [31:0] wdata, rdata, q;
   logic [3:0] ben;
   logic [15:0] exp;
   wcbc_beat_t beat;
   wcbc_width_t w;
   int n_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   wcbc_top wcbc_top_inst (.MCLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
      .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(ben), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq),
      .WR_VALID_I(vld), .WR_FIRST_I(fst), .WR_A2_I(a2p), .WR_BEAT_I(beat), .CRC_ERR_O(err), .IRQ_O(irq));
   wcbc_ctl_model wcbc_ctl_model_inst (.clk_i(clk), .valid_o(vld), .first_o(fst), .a2_o(a2p), .beat_o(beat));
   always #5 clk = ~clk;
   ////////////////////////////////////////
   task automatic give_verdict();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         n_errors++;
         give_verdict();
      end
   end
   task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= !we;
      wr <= we;
      wdata <= d;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      addr = 5'h00;
      rd = 1'b0;
      wr = 1'b0;
      wdata = 32'h0;
      ben = 4'hf;
      void'($urandom(67405));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 5'h00, 32'h0);
      `CHK(q, 32'h0)
      bus(1'b0, 5'h10, 32'h0);
      `CHK(q, 32'h0)
      bus(1'b0, 5'h1c, 32'h0);
      `CHK(q, 32'h0)
      // a frame while crc is off must leave no trace
      wcbc_ctl_model_inst.send(1'b0, WCBC_X8, 1'b0, 1'b1, 1'b0, 1'b0, exp);
      repeat (4) @(posedge clk);
      bus(1'b0, 5'h08, 32'h0);
      `CHK(q, 32'h0)
      bus(1'b1, 5'h10, 32'h1);
      for (int i = 0; i < 24; i++) begin
         w = wcbc_width_t'(i % 3);
         a2 = 1'((i / 3) % 2);
         men = 1'((i / 6) % 2);
         bad = 1'(i / 12);
         shp = ((i % 4) == 1);
         bus(1'b1, 5'h00, 32'({men, w, 2'b11}));
         wcbc_ctl_model_inst.send(a2, w, men, bad, shp, 1'($urandom), exp);
         repeat (4) @(posedge clk);
         `CHK(err, bad)
         `CHK(irq, bad)
         bus(1'b0, 5'h08, 32'h0);
         `CHK(q, {29'h0, shp, 1'b1, bad})
         bus(1'b0, 5'h14, 32'h0);
         `CHK(q[7:0], exp[7:0])
         `CHK(q[23:16], exp[7:0] ^ {7'h0, bad})
         if (w == WCBC_X16) begin
            `CHK(q[15:8], exp[15:8])
            `CHK(q[31:24], exp[15:8])
         end
         bus(1'b1, 5'h04, 32'h8);
         bus(1'b0, 5'h04, 32'h0);
         `CHK(q[3], bad)
         bus(1'b1, 5'h04, 32'h0);
         bus(1'b1, 5'h0c, 32'h7);
         `CHK(err, 1'b0)
      end
      bus(1'b0, 5'h18, 32'h0);
      `CHK(q, 32'h18)
      // a write without the low byte enabled must leave the control word alone
      ben <= 4'he;
      bus(1'b1, 5'h00, 32'h0);
      ben <= 4'hf;
      bus(1'b0, 5'h00, 32'h0);
      `CHK(q, 32'({men, w, 2'b11}))
      give_verdict();
   end
endmodule // wcbc_tb_top
bind wcbc_top wcbc_chk wcbc_chk_inst (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
   .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
   .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
   .WR_VALID_I(WR_VALID_I), .WR_FIRST_I(WR_FIRST_I), .WR_A2_I(WR_A2_I), .WR_BEAT_I(WR_BEAT_I),
   .CRC_ERR_O(CRC_ERR_O), .IRQ_O(IRQ_O));
